// File: src/compare_pulse_shaper.sv
// Pulse stretcher and contact polarity stage for the compare output pin
`timescale 1ns/1ps
module compare_pulse_shaper
	import pcmp_pkg::*;
#(
	parameter int unsigned W = WIDTH_W
)
(
	// Clock, reset, enable
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// Control
	input wire logic fire_i,
	input wire logic [W-1:0] width_i,
	input wire logic normally_closed_i,
	// Pin
	output logic pin_o
);
	logic [W-1:0] remain;
	logic [W-1:0] next_remain;
	logic level;
	logic next_level;

	// A new match restarts the pulse; back-to-back matches merge into one long pulse
	always_comb
	begin
		next_remain = remain;
		next_level = level;
		if (fire_i)
		begin
			next_remain = (width_i == '0) ? W'(1) : width_i;
			next_level = 1'b1;
		end
		else if (remain > W'(1))
		begin
			next_remain = remain - W'(1);
		end
		else
		begin
			next_remain = '0;
			next_level = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			remain <= '0;
			level <= 1'b0;
		end
		else if (ce_i)
		begin
			remain <= next_remain;
			level <= next_level;
		end
	end

	// Normally closed contact idles high and opens for the pulse
	assign pin_o = level ^ normally_closed_i; // [RL15]
endmodule : compare_pulse_shaper

// File: src/pcmp_pkg.sv
// Package for the position compare pulse unit: register map, fields, constants
// Notes on behaviour
// RL1 - Targets read from array at start index
// RL2 - Software keeps start plus count inside array
// RL3 - Targets are signed 32-bit pulse positions
// RL4 - Match on crossing, not only equality
// RL5 - Enable bit 0 starts at first entry
// RL6 - One pulse per match, then next entry; matches within the pulse width merge into one pulse
// RL7 - Count decrements per match, stops at zero
// RL8 - Last target is start plus count minus one
// RL9 - Enable bit 0 clears on completion
// RL10 - Enable with zero count: clear, no start
// RL11 - Continuous mode wraps to first entry forever
// RL12 - Auto capture starts after last match
// RL13 - Pulse on dedicated pin within 1 us
// RL14 - Source axis selectable and readable back
// RL15 - Pulse width programmable, polarity selectable
// RL16 - Crossing from previous and current samples
package pcmp_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned RESPONSE_NS = 1000;
	localparam int unsigned RESPONSE_CYC = RESPONSE_NS / (1_000_000_000 / CLK_HZ);
	localparam int unsigned BUS_AW = 4;
	localparam int unsigned BUS_DW = 32;
	localparam int unsigned POS_W = 32;
	localparam int unsigned WIDTH_W = 16;

	localparam logic [BUS_AW-1:0] OFS_CONTROL = 4'h0;
	localparam logic [BUS_AW-1:0] OFS_START = 4'h1;
	localparam logic [BUS_AW-1:0] OFS_COUNT = 4'h2;
	localparam logic [BUS_AW-1:0] OFS_SOURCE = 4'h3;
	localparam logic [BUS_AW-1:0] OFS_WIDTH = 4'h4;
	localparam logic [BUS_AW-1:0] OFS_STATUS = 4'h5;
	localparam logic [BUS_AW-1:0] OFS_MASK = 4'h6;
	localparam logic [BUS_AW-1:0] OFS_TARGET = 4'h7;
	localparam logic [BUS_AW-1:0] OFS_ARR_ADDR = 4'h8;
	localparam logic [BUS_AW-1:0] OFS_ARR_DATA = 4'h9;

	localparam logic [WIDTH_W-1:0] WIDTH_RST = 16'h0001;

	typedef enum logic [1:0]
	{
		SRC_MAIN = 2'b00,
		SRC_AUX = 2'b01,
		SRC_PULSE = 2'b10,
		SRC_CAPTURE = 2'b11
	} source_e;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_ARM = 2'b01,
		ST_RUN = 2'b10
	} state_e;

	typedef struct packed
	{
		logic [27:0] rsvd;
		logic normally_closed;
		logic auto_capture;
		logic continuous;
		logic enable;
	} ctrl_s;

	typedef struct packed
	{
		logic [27:0] rsvd;
		logic wrapped;
		logic zero_abort;
		logic done;
		logic matched;
	} status_s;

	typedef struct packed
	{
		logic signed [POS_W-1:0] main_enc;
		logic signed [POS_W-1:0] aux_scale;
		logic signed [POS_W-1:0] pulse_cmd;
		logic signed [POS_W-1:0] capture_axis;
	} axis_pos_s;

	localparam ctrl_s CTRL_RST = '0;
	localparam status_s STATUS_RST = '0;
endpackage : pcmp_pkg

// File: src/position_compare_pulse_unit.sv
// Position compare unit: target table, crossing detector, register port
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module position_compare_pulse_unit
	import pcmp_pkg::*;
#(
	parameter int unsigned ARRAY_DEPTH = 64,
	parameter int unsigned IDX_W = $clog2(ARRAY_DEPTH)
)
(
	// Clock, reset, enable
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// Register port
	input wire logic [BUS_AW-1:0] addr_i,
	input wire logic [BUS_DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [BUS_DW-1:0] rdata_o,
	// Axis positions
	input wire axis_pos_s axis_pos_i,
	// Outputs
	output logic compare_pulse_output_o,
	output logic capture_start_o,
	output logic busy_o,
	output logic irq_o
);
	logic signed [POS_W-1:0] mem [ARRAY_DEPTH];

	state_e state;
	state_e next_state;
	ctrl_s ctrl;
	ctrl_s next_ctrl;
	status_s status;
	status_s next_status;
	status_s mask;
	status_s next_mask;
	logic [IDX_W-1:0] start_idx;
	logic [IDX_W-1:0] next_start_idx;
	logic [IDX_W-1:0] cur_idx;
	logic [IDX_W-1:0] next_cur_idx;
	logic [IDX_W:0] count;
	logic [IDX_W:0] next_count;
	logic [IDX_W:0] lap_count;
	logic [IDX_W:0] next_lap_count;
	source_e source;
	source_e next_source;
	logic [WIDTH_W-1:0] width;
	logic [WIDTH_W-1:0] next_width;
	logic [IDX_W-1:0] arr_addr;
	logic [IDX_W-1:0] next_arr_addr;
	logic signed [POS_W-1:0] prev_pos;
	logic signed [POS_W-1:0] next_prev_pos;
	logic fire;
	logic next_fire;
	logic cap_pulse;
	logic next_cap_pulse;
	logic [BUS_DW-1:0] rdata;
	logic [BUS_DW-1:0] next_rdata;
	logic mem_we;
	logic signed [POS_W-1:0] cur_pos;
	logic signed [POS_W-1:0] target;
	logic hit;
	ctrl_s wctrl;
	status_s wstat;

	// Crossing test on signed values, either direction of travel
	function automatic logic crossed(input logic signed [POS_W-1:0] a,
		input logic signed [POS_W-1:0] b, input logic signed [POS_W-1:0] t);
		crossed = ((a <= t) && (b >= t)) || ((a >= t) && (b <= t));
	endfunction : crossed

	function automatic logic is_wr(input logic [BUS_AW-1:0] ofs);
		is_wr = wr_i && (addr_i == ofs);
	endfunction : is_wr

	always_comb
	begin
		case (source) // [RL14]
			SRC_MAIN: cur_pos = axis_pos_i.main_enc;
			SRC_AUX: cur_pos = axis_pos_i.aux_scale;
			SRC_PULSE: cur_pos = axis_pos_i.pulse_cmd;
			SRC_CAPTURE: cur_pos = axis_pos_i.capture_axis;
			default: cur_pos = axis_pos_i.main_enc;
		endcase
	end

	// Asynchronous table read keeps the crossing-to-pin path at two flops
	assign target = mem[cur_idx]; // [RL1] [RL3]
	assign hit = (state == ST_RUN) && crossed(prev_pos, cur_pos, target); // [RL4] [RL16]
	assign wctrl = ctrl_s'(wdata_i);
	assign wstat = status_s'(wdata_i);
	// Written out here: a continuous assign would not wake on the strobe inside a function
	assign mem_we = wr_i && (addr_i == OFS_ARR_DATA);

	always_comb
	begin
		next_state = state;
		next_ctrl = ctrl;
		next_status = status;
		next_mask = mask;
		next_start_idx = start_idx;
		next_cur_idx = cur_idx;
		next_count = count;
		next_lap_count = lap_count;
		next_source = source;
		next_width = width;
		next_arr_addr = arr_addr;
		next_prev_pos = cur_pos;
		next_fire = 1'b0;
		next_cap_pulse = 1'b0;
		next_rdata = '0;

		// Status clears first so that hardware events below win over the write
		if (is_wr(OFS_STATUS))
		begin
			next_status = status & ~wstat;
			next_status.rsvd = '0;
		end
		if (is_wr(OFS_MASK))
		begin
			next_mask = wstat;
			next_mask.rsvd = '0;
		end
		if (is_wr(OFS_WIDTH))
		begin
			next_width = wdata_i[WIDTH_W-1:0];
		end
		if (is_wr(OFS_ARR_ADDR))
		begin
			next_arr_addr = wdata_i[IDX_W-1:0];
		end
		if (mem_we)
		begin
			next_arr_addr = arr_addr + IDX_W'(1);
		end
		// Table position and count are frozen while a sequence runs
		if (state == ST_IDLE)
		begin
			if (is_wr(OFS_START))
			begin
				next_start_idx = wdata_i[IDX_W-1:0];
			end
			if (is_wr(OFS_COUNT))
			begin
				next_count = wdata_i[IDX_W:0];
			end
		end
		// The capture axis source stays locked while comparing against it
		if (is_wr(OFS_SOURCE) && !((state != ST_IDLE) && (source == SRC_CAPTURE)))
		begin
			next_source = source_e'(wdata_i[1:0]); // [RL14]
		end
		if (is_wr(OFS_CONTROL))
		begin
			next_ctrl = wctrl;
			next_ctrl.rsvd = '0;
		end

		case (state)
			ST_IDLE:
			begin
				if (next_ctrl.enable)
				begin
					if (next_count == '0)
					begin
						next_ctrl.enable = 1'b0; // [RL10]
						next_status.zero_abort = 1'b1;
					end
					else
					begin
						next_cur_idx = next_start_idx; // [RL5]
						next_lap_count = next_count;
						next_state = ST_ARM;
					end
				end
			end
			ST_ARM:
			begin
				// One cycle to load a fresh previous sample for the new source
				if (!next_ctrl.enable)
				begin
					next_state = ST_IDLE;
				end
				else
				begin
					next_state = ST_RUN;
				end
			end
			ST_RUN:
			begin
				if (hit)
				begin
					next_fire = 1'b1; // [RL6] [RL13]
					next_status.matched = 1'b1;
					next_cur_idx = cur_idx + IDX_W'(1); // [RL2]
					next_count = count - (IDX_W+1)'(1); // [RL7]
					if (count == (IDX_W+1)'(1))
					begin
						// Entry at start plus count minus one was just matched
						next_cap_pulse = ctrl.auto_capture; // [RL8] [RL12]
						if (ctrl.continuous)
						begin
							next_cur_idx = start_idx; // [RL11]
							next_count = lap_count;
							next_status.wrapped = 1'b1;
						end
						else
						begin
							next_ctrl.enable = 1'b0; // [RL9]
							next_status.done = 1'b1;
							next_state = ST_IDLE;
						end
					end
				end
				else if (!next_ctrl.enable)
				begin
					next_state = ST_IDLE;
				end
				// Software stop after a hit still leaves the pulse and count update
				if (hit && !next_ctrl.enable)
				begin
					next_state = ST_IDLE;
				end
			end
			default:
			begin
				next_state = ST_IDLE;
			end
		endcase

		if (rd_i)
		begin
			case (addr_i)
				OFS_CONTROL: next_rdata = BUS_DW'(ctrl);
				OFS_START: next_rdata = BUS_DW'(start_idx);
				OFS_COUNT: next_rdata = BUS_DW'(count);
				OFS_SOURCE: next_rdata = BUS_DW'(source);
				OFS_WIDTH: next_rdata = BUS_DW'(width);
				OFS_STATUS: next_rdata = BUS_DW'(status);
				OFS_MASK: next_rdata = BUS_DW'(mask);
				OFS_TARGET: next_rdata = BUS_DW'(target);
				OFS_ARR_ADDR: next_rdata = BUS_DW'(arr_addr);
				OFS_ARR_DATA: next_rdata = BUS_DW'(mem[arr_addr]);
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			state <= ST_IDLE;
			ctrl <= CTRL_RST;
			status <= STATUS_RST;
			mask <= STATUS_RST;
			start_idx <= '0;
			cur_idx <= '0;
			count <= '0;
			lap_count <= '0;
			source <= SRC_MAIN;
			width <= WIDTH_RST;
			arr_addr <= '0;
			prev_pos <= '0;
			fire <= 1'b0;
			cap_pulse <= 1'b0;
			rdata <= '0;
		end
		else if (ce_i)
		begin
			state <= next_state;
			ctrl <= next_ctrl;
			status <= next_status;
			mask <= next_mask;
			start_idx <= next_start_idx;
			cur_idx <= next_cur_idx;
			count <= next_count;
			lap_count <= next_lap_count;
			source <= next_source;
			width <= next_width;
			arr_addr <= next_arr_addr;
			prev_pos <= next_prev_pos;
			fire <= next_fire;
			cap_pulse <= next_cap_pulse;
			rdata <= next_rdata;
		end
	end

	// Table storage has no reset; software fills it before enabling
	always_ff @(posedge core_clk_i)
	begin
		if (ce_i && mem_we)
		begin
			mem[arr_addr] <= signed'(wdata_i);
		end
	end

	compare_pulse_shaper #(
		.W(WIDTH_W)
	) u_shaper (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.fire_i(fire),
		.width_i(width),
		.normally_closed_i(ctrl.normally_closed),
		.pin_o(compare_pulse_output_o) // [RL13] [RL15]
	);

	assign rdata_o = rdata;
	assign capture_start_o = cap_pulse;
	assign busy_o = (state != ST_IDLE);
	assign irq_o = |(status & mask);
endmodule : position_compare_pulse_unit

// File: verif/axis_source_model.sv
// Axis model: one ramp seen four ways by the source axes
`timescale 1ns/1ps
module axis_source_model
	import pcmp_pkg::*;
(
	// Clock, reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Ramp speed, signed, pulses per cycle
	input wire logic signed [POS_W-1:0] step_i,
	// Positions
	output axis_pos_s axis_pos_o
);
	logic signed [POS_W-1:0] pos;
	always_ff @(posedge core_clk_i)
	begin
		pos <= srst_i ? '0 : pos + step_i;
	end
	// Aux runs backwards so a wrong source never crosses the same targets
	assign axis_pos_o = {pos, -pos, pos <<< 1, pos - 32'sh5};
endmodule : axis_source_model

// File: verif/pcmp_asserts.sv
// Port checker for the position compare unit
`timescale 1ns/1ps
module pcmp_asserts
	import pcmp_pkg::*;
#(
	parameter int unsigned ARRAY_DEPTH = 64
)
(
	// Clock, reset, enable
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// Register port
	input wire logic [BUS_AW-1:0] addr_i,
	input wire logic [BUS_DW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [BUS_DW-1:0] rdata_o,
	// Axis and outputs
	input wire axis_pos_s axis_pos_i,
	input wire logic compare_pulse_output_o,
	input wire logic capture_start_o,
	input wire logic busy_o,
	input wire logic irq_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);
	property p_rd_idle; !$past(rd_i) |-> rdata_o == '0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data off slot");
	property p_src; $past(rd_i) && $past(addr_i) == OFS_SOURCE |-> rdata_o[31:2] == '0; endproperty
	a_src: assert property (p_src) else $error("source readback wide");
	property p_start;
		$rose(busy_o) |-> $past(wr_i) && $past(addr_i) == OFS_CONTROL && ($past(wdata_i) & 32'h1);
	endproperty
	a_start: assert property (p_start) else $error("busy without enable");
	property p_cap_one; capture_start_o |=> !capture_start_o; endproperty
	a_cap_one: assert property (p_cap_one) else $error("capture start too long");
	property p_cap_src; capture_start_o |-> $past(busy_o); endproperty
	a_cap_src: assert property (p_cap_src) else $error("capture start while idle");
	// Contact polarity tracked from control writes, so the pulse end of a closed contact is no event
	logic nc_seen;
	logic act_lvl;
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			nc_seen <= 1'b0;
		end
		else if (ce_i && wr_i && (addr_i == OFS_CONTROL))
		begin
			nc_seen <= wdata_i[3];
		end
	end
	assign act_lvl = compare_pulse_output_o ^ nc_seen;
	property p_pin; $rose(act_lvl) |-> $past(busy_o, 2); endproperty
	a_pin: assert property (p_pin) else $error("pin went active without cause");
	property p_done; $fell(busy_o) && !$past(wr_i) |=> $changed(compare_pulse_output_o); endproperty
	a_done: assert property (p_done) else $error("last match gave no pulse");
	property p_irq_up; $rose(irq_o) |-> $past(busy_o) || $past(wr_i); endproperty
	a_irq_up: assert property (p_irq_up) else $error("irq rose without event");
	property p_irq_dn; $fell(irq_o) && !$past(srst_i) |-> $past(wr_i); endproperty
	a_irq_dn: assert property (p_irq_dn) else $error("irq fell without write");
	c_cap: cover property (capture_start_o);
	c_done: cover property ($fell(busy_o));
	c_irq: cover property ($rose(irq_o));
endmodule : pcmp_asserts

bind position_compare_pulse_unit pcmp_asserts #(.ARRAY_DEPTH(ARRAY_DEPTH)) pcmp_asserts_inst (
	.core_clk_i, .srst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .axis_pos_i,
	.compare_pulse_output_o, .capture_start_o, .busy_o, .irq_o
);

// File: verif/testbench.sv
// Self-checking bench for the position compare unit
`timescale 1ns/1ps
module testbench
	import pcmp_pkg::*;
;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic ce_i = 1'b1;
	logic [BUS_AW-1:0] addr_i = '0;
	logic [BUS_DW-1:0] wdata_i = '0;
	logic signed [POS_W-1:0] step = '0;
	logic [BUS_DW-1:0] rdata_o;
	logic compare_pulse_output_o, capture_start_o, busy_o, irq_o;
	axis_pos_s axis_pos_i;
	logic [31:0] tbl [4] = '{32'h28, 32'h50, 32'h78, 32'h64};
	int failures = 0;
	int checks = 0;
	int pulses = 0;
	int act = 0;
	int caps = 0;
	logic nc = 1'b0;
	logic prev_pin = 1'b0;

	always #25 core_clk_i = ~core_clk_i;

	position_compare_pulse_unit #(.ARRAY_DEPTH(8)) position_compare_pulse_unit_inst (
		.core_clk_i, .srst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.axis_pos_i, .compare_pulse_output_o, .capture_start_o, .busy_o, .irq_o
	);
	axis_source_model axis_source_model_inst (
		.core_clk_i, .srst_i, .step_i(step), .axis_pos_o(axis_pos_i)
	);

	// Pulses counted as moves to the active contact level
	always @(posedge core_clk_i)
	begin
		if (compare_pulse_output_o !== prev_pin && compare_pulse_output_o === ~nc)
			pulses++;
		if (compare_pulse_output_o === ~nc)
			act++;
		if (capture_start_o === 1'b1)
			caps++;
		prev_pin <= compare_pulse_output_o;
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
		@(posedge core_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(n, rdata_o, e);
	endtask : rd

	task automatic wait_p(input int n);
		for (int k = 0; k < 400 && pulses < n; k++)
			@(posedge core_clk_i);
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask : wait_p

	task automatic report_and_stop;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	initial
	begin
		#400000;
		failures++;
		report_and_stop();
	end

	initial
	begin
		repeat (12) @(posedge core_clk_i);
		srst_i <= 1'b0;
		rd(OFS_WIDTH, 32'h1, "width");
		rd(OFS_SOURCE, 32'h0, "source");
		rd(4'hF, 32'h0, "unmapped");
		$display("test reset done");
		wr(OFS_MASK, 32'h4);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_CONTROL, 32'h1);
		rd(OFS_CONTROL, 32'h0, "ctl");
		rd(OFS_STATUS, 32'h4, "status");
		chk("irq", irq_o, 1'b1);
		chk("busy", busy_o, 1'b0);
		wr(OFS_STATUS, 32'h4);
		chk("irq clr", irq_o, 1'b0);
		$display("test zero count done");
		// Step of 3 jumps over 40 and 80; entry 5 lies at start plus count, one past the last entry, so it is never compared
		wr(OFS_ARR_ADDR, 32'h2);
		foreach (tbl[i])
			wr(OFS_ARR_DATA, tbl[i]);
		wr(OFS_START, 32'h2);
		wr(OFS_COUNT, 32'h3);
		wr(OFS_WIDTH, 32'h3);
		wr(OFS_CONTROL, 32'h9);
		nc = 1'b1;
		chk("idle", compare_pulse_output_o, 1'b1);
		rd(OFS_TARGET, 32'h28, "target");
		pulses = 0;
		act = 0;
		@(posedge core_clk_i);
		step <= 32'sh3;
		wait_p(3);
		chk("pulses", pulses, 3);
		chk("active", act, 9);
		chk("busy", busy_o, 1'b0);
		chk("masked", irq_o, 1'b0);
		rd(OFS_CONTROL, 32'h8, "ctl");
		rd(OFS_COUNT, 32'h0, "count");
		rd(OFS_STATUS, 32'h3, "status");
		wr(OFS_MASK, 32'h3);
		chk("irq", irq_o, 1'b1);
		// A clear written while the clock enable is low must not land
		@(posedge core_clk_i);
		ce_i <= 1'b0;
		wr(OFS_STATUS, 32'h3);
		@(posedge core_clk_i);
		ce_i <= 1'b1;
		#1;
		chk("frozen", irq_o, 1'b1);
		wr(OFS_STATUS, 32'h3);
		chk("cleared", irq_o, 1'b0);
		$display("test table done");
		@(posedge core_clk_i);
		srst_i <= 1'b1;
		step <= '0;
		repeat (2) @(posedge core_clk_i);
		srst_i <= 1'b0;
		#1;
		nc = 1'b0;
		wr(OFS_ARR_ADDR, 32'h6);
		wr(OFS_ARR_DATA, 32'hFFFFFFE2);
		wr(OFS_ARR_DATA, 32'hFFFFFFC4);
		wr(OFS_START, 32'h6);
		wr(OFS_COUNT, 32'h2);
		wr(OFS_SOURCE, 32'h1);
		wr(OFS_WIDTH, 32'h0);
		wr(OFS_CONTROL, 32'h7);
		rd(OFS_SOURCE, 32'h1, "source");
		pulses = 0;
		caps = 0;
		act = 0;
		@(posedge core_clk_i);
		step <= 32'sh3;
		wait_p(2);
		chk("caps", caps, 1);
		chk("active", act, 2);
		chk("busy", busy_o, 1'b1);
		rd(OFS_STATUS, 32'h9, "status");
		// Reversing brings the aux axis back up through the first entry
		@(posedge core_clk_i);
		step <= -32'sh3;
		wait_p(3);
		chk("pulses", pulses, 3);
		$display("test continuous done");
		// Axis held still so the capture axis sequence cannot finish under the lock check
		@(posedge core_clk_i);
		step <= '0;
		wr(OFS_CONTROL, 32'h0);
		wr(OFS_COUNT, 32'h1);
		wr(OFS_SOURCE, 32'h3);
		wr(OFS_CONTROL, 32'h1);
		wr(OFS_SOURCE, 32'h0);
		wr(OFS_START, 32'h0);
		rd(OFS_SOURCE, 32'h3, "locked");
		rd(OFS_START, 32'h6, "start");
		chk("busy", busy_o, 1'b1);
		wr(OFS_CONTROL, 32'h0);
		wr(OFS_SOURCE, 32'h2);
		rd(OFS_SOURCE, 32'h2, "pulse src");
		$display("test source lock done");
		report_and_stop();
	end
endmodule : testbench
